//--- pcg_params.svh
// Register offsets, field positions, reset values and fixed counts of the CRC generator.
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH

`define PCG_AW 4
`define PCG_OFF_CTL 4'h0
`define PCG_OFF_TAP 4'h4
`define PCG_OFF_DAT 4'h8

`define PCG_CTL_PLEN_MSB 3
`define PCG_CTL_GO 4
`define PCG_CTL_EMPTY 6
`define PCG_CTL_FULL 7
`define PCG_CTL_CNT_LSB 8
`define PCG_CTL_CNT_MSB 12
`define PCG_CTL_IDLE 13

`define PCG_PLEN_RST 4'h0
`define PCG_TAP_RST 16'h0000
`define PCG_TAP_MASK 16'hfffe
`define PCG_PLEN_NARROW_MAX 4'h7
`define PCG_DEPTH_WIDE 5'h08
`define PCG_DEPTH_NARROW 5'h10

`define PCG_RESP_OKAY 2'b00
`define PCG_RESP_SLVERR 2'b10

`endif

//--- pcg_pkg.sv
// Types shared by the CRC generator modules.
package pcg_pkg;

  typedef logic [15:0] pcg_word_t;
  typedef logic [3:0] pcg_ptr_t;
  typedef logic [4:0] pcg_cnt_t;

  typedef enum logic {
    SH_IDLE,
    SH_RUN
  } pcg_sh_state_t;

endpackage : pcg_pkg

//--- pcg_fifo_if.sv
// Write and read port bundle between the controller and the FIFO storage.
interface pcg_fifo_if;
  import pcg_pkg::*;

  logic we;
  pcg_ptr_t waddr;
  pcg_word_t wdata;
  pcg_ptr_t raddr;
  pcg_word_t rdata;

  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);

endinterface : pcg_fifo_if

//--- pcg_fifo_mem.sv
// Sixteen-word FIFO storage with a registered, write-through read port.
module pcg_fifo_mem
  import pcg_pkg::*;
(
  input wire logic clk_i,
  pcg_fifo_if.mem port
);

  pcg_word_t mem_q [16];
  pcg_word_t rdata_q;

  // The read address is the next read pointer, so the word under the shifter
  // is ready in the cycle it becomes current; a write to that very entry passes through.
  always_ff @(posedge clk_i) begin
    if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
    if (port.we && (port.waddr == port.raddr)) begin
      rdata_q <= port.wdata;
    end else begin
      rdata_q <= mem_q[port.raddr];
    end
  end

  assign port.rdata = rdata_q;

endmodule : pcg_fifo_mem

//--- pcg_crc_engine.sv
// Programmable feedback shift register that takes one data bit per enabled cycle.
module pcg_crc_engine
  import pcg_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic bit_i,
  input wire logic [3:0] plen_i,
  input wire pcg_word_t taps_i,
  output pcg_word_t crc_o
);

  pcg_word_t crc_q;
  pcg_word_t crc_d;
  pcg_word_t poly;
  pcg_word_t width_mask;
  logic fb;

  assign width_mask = 16'hffff >> (4'hf - plen_i);  // see [R17]
  assign poly = {taps_i[15:1], 1'b1};  // see [R2]
  assign fb = bit_i ^ crc_q[plen_i];  // see [R1]
  assign crc_d = ({crc_q[14:0], 1'b0} ^ ({16{fb}} & poly)) & width_mask;  // see [R1] see [R3]

  always_ff @(posedge clk_i) begin
    if (srst_i || clr_i) begin
      crc_q <= 16'h0000;
    end else if (en_i) begin
      crc_q <= crc_d;  // see [R9]
    end
  end

  assign crc_o = crc_q;

endmodule : pcg_crc_engine

//--- pcg_top.sv
// CRC generator top: AXI4-Lite registers, input FIFO control and serial shifter.
//
// What this block does
// [R1] Taps and length come from software registers.
// [R2] Constant term and top term always applied.
// [R3] Taps 12 and 5, length 1111: degree sixteen.
// [R4] Software writes run bit to start shifting.
// [R5] FIFO depth eight above length seven, else sixteen.
// [R6] Byte writes accepted; narrow units written whole.
// [R7] Count increments when write reaches top byte.
// [R8] Shift while running and count nonzero; decrement.
// [R9] One clock per data bit.
// [R10] Full at depth, empty at zero count.
// [R11] Write while full wraps count, no interrupt.
// [R12] Interrupt when count falls from one to zero.
// [R13] Software prefills, then polls count before writing.
// [R14] Software flushes by running until empty.
// [R15] Software reads result only once empty.
// [R16] Software waits a cycle before reading count.
// [R17] Length field is degree minus one.
// [R18] Cleared run bit drains FIFO then stops.
// [R19] Sleep freezes the shifter in place; register writes and FIFO pushes still proceed.
// [R20] Idle-stop bit makes idle act as sleep.
// [R21] Bits above width ignored; MSB shifted first.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`include "pcg_params.svh"

module pcg_top
  import pcg_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sleep_i,
  input wire logic idle_i,
  input wire logic [`PCG_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PCG_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_o
);

  // ---------------------------------------------------------------------------
  // Power-state inputs
  // ---------------------------------------------------------------------------
  logic [1:0] sleep_sync_q;
  logic [1:0] idle_sync_q;
  logic freeze;
  logic idle_stop_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sleep_sync_q <= 2'b00;
      idle_sync_q <= 2'b00;
    end else begin
      sleep_sync_q <= {sleep_sync_q[0], sleep_i};
      idle_sync_q <= {idle_sync_q[0], idle_i};
    end
  end

  assign freeze = sleep_sync_q[1] || (idle_sync_q[1] && idle_stop_q);  // see [R19] see [R20]

  // ---------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------------------
  logic aw_hold_q;
  logic w_hold_q;
  logic [`PCG_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_take;
  logic w_take;
  logic wr_commit;
  logic aw_hold_d;
  logic w_hold_d;
  logic wr_ctl;
  logic wr_tap;
  logic wr_dat;
  logic wr_hit;

  assign aw_take = s_axi_awvalid && awready_q;
  assign w_take = s_axi_wvalid && wready_q;
  assign wr_commit = aw_hold_q && w_hold_q && !bvalid_q;
  assign aw_hold_d = aw_take || (aw_hold_q && !wr_commit);
  assign w_hold_d = w_take || (w_hold_q && !wr_commit);
  assign wr_ctl = wr_commit && (aw_addr_q == `PCG_OFF_CTL);
  assign wr_tap = wr_commit && (aw_addr_q == `PCG_OFF_TAP);
  assign wr_dat = wr_commit && (aw_addr_q == `PCG_OFF_DAT);
  assign wr_hit = wr_ctl || wr_tap || wr_dat;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `PCG_RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awready_q <= !aw_hold_d;
      wready_q <= !w_hold_d;
      if (wr_commit) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (aw_take) begin
      aw_addr_q <= {s_axi_awaddr[`PCG_AW-1:2], 2'b00};
    end
    if (w_take) begin
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  logic [3:0] plen_q;
  logic go_q;
  pcg_word_t taps_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      plen_q <= `PCG_PLEN_RST;
      go_q <= 1'b0;
      idle_stop_q <= 1'b0;
      taps_q <= `PCG_TAP_RST;
    end else begin
      if (wr_ctl && w_strb_q[0]) begin
        plen_q <= w_data_q[`PCG_CTL_PLEN_MSB:0];  // see [R1] see [R17]
        go_q <= w_data_q[`PCG_CTL_GO];  // see [R4] see [R18]
      end
      if (wr_ctl && w_strb_q[1]) begin
        idle_stop_q <= w_data_q[`PCG_CTL_IDLE];  // see [R20]
      end
      if (wr_tap && w_strb_q[0]) begin
        taps_q[7:0] <= w_data_q[7:0] & 8'(`PCG_TAP_MASK);  // see [R2]
      end
      if (wr_tap && w_strb_q[1]) begin
        taps_q[15:8] <= w_data_q[15:8];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // FIFO bookkeeping
  // ---------------------------------------------------------------------------
  pcg_fifo_if fifo ();
  pcg_word_t stage_q;
  pcg_word_t stage_d;
  pcg_word_t width_mask;
  pcg_ptr_t wr_ptr_q;
  pcg_ptr_t rd_ptr_q;
  pcg_ptr_t rd_ptr_d;
  pcg_ptr_t ptr_mask;
  pcg_cnt_t cnt_q;
  pcg_cnt_t cnt_d;
  pcg_cnt_t depth;
  logic top_lane;
  logic push;
  logic pop;
  logic full;
  logic empty;
  logic wrap;

  assign depth = (plen_q > `PCG_PLEN_NARROW_MAX) ? `PCG_DEPTH_WIDE : `PCG_DEPTH_NARROW;  // see [R5]
  assign ptr_mask = depth[3:0] - 4'h1;
  assign full = (cnt_q == depth);  // see [R10]
  assign empty = (cnt_q == 5'h00);  // see [R10]
  assign width_mask = 16'hffff >> (4'hf - plen_q);
  assign stage_d = {w_strb_q[1] ? w_data_q[15:8] : stage_q[15:8],
                    w_strb_q[0] ? w_data_q[7:0] : stage_q[7:0]};  // see [R6]
  assign top_lane = plen_q[3] ? w_strb_q[1] : w_strb_q[0];
  assign push = wr_dat && top_lane;  // see [R7]
  assign wrap = push && full;  // see [R11]
  assign rd_ptr_d = wrap ? ((wr_ptr_q + 4'h1) & ptr_mask)
                  : pop ? ((rd_ptr_q + 4'h1) & ptr_mask) : rd_ptr_q;

  always_comb begin
    cnt_d = cnt_q;
    if (wrap) begin
      cnt_d = 5'h00;  // see [R11]
    end else if (push && !pop) begin
      cnt_d = cnt_q + 5'h01;  // see [R7]
    end else if (pop && !push) begin
      cnt_d = cnt_q - 5'h01;  // see [R8]
    end
  end

  assign fifo.we = push;
  assign fifo.waddr = wr_ptr_q;
  assign fifo.wdata = stage_d & width_mask;  // see [R21]
  assign fifo.raddr = rd_ptr_d;

  pcg_fifo_mem u_mem (
    .clk_i(clk_i),
    .port(fifo.mem)
  );

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stage_q <= 16'h0000;
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      cnt_q <= 5'h00;
    end else begin
      if (wr_dat) begin
        stage_q <= stage_d;
      end
      if (push) begin
        wr_ptr_q <= (wr_ptr_q + 4'h1) & ptr_mask;
      end
      rd_ptr_q <= rd_ptr_d;
      cnt_q <= cnt_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Serial shifter
  // ---------------------------------------------------------------------------
  pcg_sh_state_t state_q;
  pcg_sh_state_t state_d;
  logic [3:0] bit_q;
  logic shift_en;
  logic irq_q;
  pcg_word_t crc;

  // Shifting pauses while frozen, so no bit and no count change is lost.
  assign shift_en = (state_q == SH_RUN) && !empty && !freeze && !wrap;  // see [R8] see [R19]
  assign pop = shift_en && (bit_q == 4'h0);  // see [R8]

  always_comb begin
    case (state_q)
      SH_IDLE: state_d = (go_q && !empty && !freeze) ? SH_RUN : SH_IDLE;  // see [R8]
      SH_RUN: state_d = (!go_q && (cnt_d == 5'h00)) ? SH_IDLE : SH_RUN;  // see [R18]
      default: state_d = SH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= SH_IDLE;
      bit_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (wrap || (state_q == SH_IDLE) || pop) begin
        bit_q <= plen_q;  // see [R21]
      end else if (shift_en) begin
        bit_q <= bit_q - 4'h1;  // see [R9]
      end
      irq_q <= pop && (cnt_q == 5'h01) && !push;  // see [R12]
    end
  end

  pcg_crc_engine u_engine (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .clr_i(wr_tap),
    .en_i(shift_en),
    .bit_i(fifo.rdata[bit_q]),
    .plen_i(plen_q),
    .taps_i(taps_q),
    .crc_o(crc)
  );

  // ---------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------------------
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_take;
  logic [`PCG_AW-1:0] ar_addr;
  logic [31:0] ctl_view;
  logic [31:0] rd_mux;
  logic rd_hit;

  assign ar_take = s_axi_arvalid && arready_q;
  assign ar_addr = {s_axi_araddr[`PCG_AW-1:2], 2'b00};
  assign ctl_view = {18'h00000, idle_stop_q, cnt_q, full, empty, 1'b0, go_q, plen_q};  // see [R10]
  assign rd_hit = (ar_addr == `PCG_OFF_CTL) || (ar_addr == `PCG_OFF_TAP)
               || (ar_addr == `PCG_OFF_DAT);
  assign rd_mux = (ar_addr == `PCG_OFF_CTL) ? ctl_view
                : (ar_addr == `PCG_OFF_TAP) ? {16'h0000, taps_q}
                : (ar_addr == `PCG_OFF_DAT) ? {16'h0000, crc} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `PCG_RESP_OKAY;
    end else begin
      arready_q <= !(ar_take || (rvalid_q && !s_axi_rready));
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq_o = irq_q;

endmodule : pcg_top

//--- pcg_checker.sv
// Port-level assertions for the CRC generator top.
`include "pcg_params.svh"
module pcg_checker (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PCG_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Bus timing and interrupt shape
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  chk_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not released");
  chk_irq_pulse: assert property (irq_o |=> !irq_o)
    else $error("interrupt longer than one cycle");
  chk_b_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && !s_axi_bvalid |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late or early");
  chk_r_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  chk_unmap_rd: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[3:2] == 2'b11 |=> s_axi_rresp == `PCG_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_rdata_hi: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read data not zero");
endmodule : pcg_checker

//--- programmable_crc_generator_tb.sv
// Self-checking bench for the CRC generator over its register bus.
`include "pcg_params.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module programmable_crc_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, srst_i = 1, sleep_i = 0, idle_i = 0;
  logic [3:0] awa = 0, ara = 0, ws = 0;
  logic [31:0] wd = 0, rdat, rd_v;
  logic awv = 0, awr, wv = 0, wr_r, bv, br = 0, arv = 0, arr, rv, rr = 0, irq_o;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] crc;
  int bad_count = 0, cmp_count = 0, irq_n = 0, j;
  pcg_top dut (.clk_i(clk_i), .srst_i(srst_i), .sleep_i(sleep_i), .idle_i(idle_i),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .irq_o(irq_o));
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (irq_o === 1'b1) irq_n++;
  // --------------------------------------------------------------
  // Bus tasks and reference model
  // --------------------------------------------------------------
  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clk_i);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_i);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
      if (bv) break;
    end
    resp = bresp;
    br <= 1'b0;
    if (i == 200) begin bad_count++; wrap_up(); end
  endtask : wr
  task automatic rd(input logic [3:0] a);
    int i;
    @(posedge clk_i);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_i);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rd_v = rdat;
    resp = rresp;
    rr <= 1'b0;
    if (i == 200) begin bad_count++; wrap_up(); end
  endtask : rd
  task automatic rc(input logic [3:0] a, input logic [31:0] e, input string n);
    rd(a);
    `CHK(n, e, rd_v)
  endtask : rc
  task automatic wait_empty();
    int k;
    for (k = 0; k < 50; k++) begin
      rd(`PCG_OFF_CTL);
      if (rd_v[`PCG_CTL_EMPTY] === 1'b1) break;
    end
    if (k == 50) begin bad_count++; wrap_up(); end
  endtask : wait_empty
  function automatic logic [15:0] crc_f(logic [15:0] c, logic [15:0] d, int p,
    logic [15:0] t);
    logic [15:0] m;
    logic fb;
    m = 16'hffff >> (15 - p);
    for (int i = p; i >= 0; i--) begin
      fb = d[i] ^ c[p];
      c = ((c << 1) ^ (fb ? (t | 16'h0001) : 16'h0000)) & m;
    end
    return c;
  endfunction : crc_f
  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rc(`PCG_OFF_CTL, 32'h0040, "ctl_rst");
    rc(`PCG_OFF_TAP, 32'h0000, "tap_rst");
    wr(`PCG_OFF_TAP, 32'h1020, 4'hf);
    wr(`PCG_OFF_CTL, 32'h000f, 4'h3);
    wr(`PCG_OFF_DAT, 32'h1234, 4'h3);
    wr(`PCG_OFF_DAT, 32'habcd, 4'h3);
    rc(`PCG_OFF_CTL, 32'h020f, "cnt_two");
    sleep_i <= 1'b1;
    wr(`PCG_OFF_CTL, 32'h001f, 4'h3);
    repeat (40) @(posedge clk_i);
    rc(`PCG_OFF_CTL, 32'h021f, "sleep_hold");
    sleep_i <= 1'b0;
    wait_empty();
    `CHK("irq_one", 1, irq_n)
    crc = crc_f(crc_f(16'h0, 16'h1234, 15, 16'h1020), 16'habcd, 15, 16'h1020);
    rc(`PCG_OFF_DAT, {16'h0, crc}, "crc16");
    wr(`PCG_OFF_CTL, 32'h000f, 4'h3);
    wr(`PCG_OFF_DAT, 32'h00ff, 4'h1);
    rc(`PCG_OFF_CTL, 32'h004f, "low_byte");
    wr(`PCG_OFF_DAT, 32'hff00, 4'h2);
    for (j = 0; j < 7; j++) wr(`PCG_OFF_DAT, j, 4'h3);
    rc(`PCG_OFF_CTL, 32'h088f, "full8");
    wr(`PCG_OFF_DAT, 32'h0, 4'h3);
    rc(`PCG_OFF_CTL, 32'h004f, "wrap8");
    wr(`PCG_OFF_CTL, 32'h0007, 4'h1);
    for (j = 0; j < 16; j++) wr(`PCG_OFF_DAT, j, 4'h1);
    rc(`PCG_OFF_CTL, 32'h1087, "full16");
    wr(`PCG_OFF_DAT, 32'h0, 4'h1);
    rc(`PCG_OFF_CTL, 32'h0047, "wrap16");
    `CHK("irq_wrap", 1, irq_n)
    wr(`PCG_OFF_TAP, 32'h0002, 4'hf);
    wr(`PCG_OFF_CTL, 32'h0003, 4'h1);
    wr(`PCG_OFF_DAT, 32'hfff5, 4'h1);
    wr(`PCG_OFF_DAT, 32'h000a, 4'h1);
    wr(`PCG_OFF_CTL, 32'h0013, 4'h1);
    wr(`PCG_OFF_CTL, 32'h0003, 4'h1);
    wait_empty();
    crc = crc_f(crc_f(16'h0, 16'h5, 3, 16'h2), 16'ha, 3, 16'h2);
    rc(`PCG_OFF_DAT, {16'h0, crc}, "crc4");
    `CHK("irq_two", 2, irq_n)
    wr(`PCG_OFF_CTL, 32'h2003, 4'h3);
    idle_i <= 1'b1;
    wr(`PCG_OFF_DAT, 32'h0003, 4'h1);
    wr(`PCG_OFF_CTL, 32'h2013, 4'h3);
    repeat (20) @(posedge clk_i);
    rc(`PCG_OFF_CTL, 32'h2113, "idle_hold");
    wr(`PCG_OFF_CTL, 32'h0013, 4'h3);
    wait_empty();
    idle_i <= 1'b0;
    `CHK("irq_three", 3, irq_n)
    crc = crc_f(crc, 16'h3, 3, 16'h2);
    rc(`PCG_OFF_DAT, {16'h0, crc}, "crc_idle");
    rd(4'hc);
    `CHK("unmap_rd", `PCG_RESP_SLVERR, resp)
    wr(4'hc, 32'hffff, 4'hf);
    `CHK("unmap_wr", `PCG_RESP_SLVERR, resp)
    rc(`PCG_OFF_CTL, 32'h0053, "ctl_kept");
    wrap_up();
  end
endmodule : programmable_crc_generator_tb
bind pcg_top pcg_checker u_chk (.clk_i(clk_i), .srst_i(srst_i),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_o(irq_o));
